// ===== pkg/ees_pkg.sv
package ees_pkg;
  localparam int NCH          = 12;
  localparam int NEV          = 8;
  localparam int NTRIG        = 4;
  localparam int NPROBE       = 4;
  localparam int AW           = 24;
  localparam int DW           = 16;
  localparam int PAW          = 12;
  localparam int NWORD        = 6;
  localparam int CH_LSB       = 5;
  localparam int MASK_LSB     = 16;
  localparam int DLY_CH_LSB   = 16;
  localparam int ARM_INV_BIT  = 12;
  localparam int RST_SEL_LSB  = 16;
  localparam int TRIG_EN_BIT  = 31;
  localparam int ST_TIMER_BIT = 16;
  localparam int ST_DLY_BIT   = 17;
  localparam int EV_OUT_CH    = 7;
  localparam logic [PAW-1:0] A_DELAY  = 12'h000;
  localparam logic [PAW-1:0] A_STATUS = 12'h004;
  localparam logic [PAW-1:0] A_TIMER  = 12'h008;
  localparam logic [PAW-1:0] A_TRIG   = 12'h010;
  localparam logic [PAW-1:0] A_CH     = 12'h100;
  localparam logic [PAW-1:0] A_CH_END = 12'h280;
  localparam logic [2:0]  W_CTRL = 3'h0;
  localparam logic [2:0]  W_ALO  = 3'h1;
  localparam logic [2:0]  W_AHI  = 3'h2;
  localparam logic [2:0]  W_DATA = 3'h3;
  localparam logic [2:0]  W_PASS = 3'h4;
  localparam logic [2:0]  W_SEQ  = 3'h5;
  localparam logic [31:0] CFG_RST   = 32'h0000_0000;
  localparam logic [31:0] DLY_WMASK = 32'h000F_FFFF;
  localparam logic [1:0]  PC_HIGH   = 2'h1;
  localparam logic [1:0]  PC_LOW    = 2'h2;

  typedef enum logic [2:0] {
    BS_PREFETCH = 3'h0, BS_DATA = 3'h1, BS_REFRESH = 3'h2,
    BS_DMA = 3'h3, BS_XFER = 3'h4, BS_OTHER = 3'h5
  } ees_bstate_e;
  typedef enum logic [2:0] {
    AR_ROM = 3'h0, AR_RAM = 3'h1, AR_IO16 = 3'h2, AR_IO8 = 3'h3,
    AR_EXT16 = 3'h4, AR_EXT8 = 3'h5, AR_XRAM = 3'h6
  } ees_area_e;
  typedef enum logic [1:0] {
    ACT_BREAK = 2'h0, ACT_TSTART = 2'h1, ACT_TSTOP = 2'h2
  } ees_act_e;
  typedef enum logic [1:0] {
    AM_ANY = 2'h0, AM_SINGLE = 2'h1, AM_RANGE = 2'h2
  } ees_amode_e;
  typedef enum logic [1:0] {
    DIR_ANY = 2'h0, DIR_READ = 2'h1, DIR_WRITE = 2'h2
  } ees_dir_e;
  typedef enum logic [1:0] {DL_IDLE = 2'h1, DL_WAIT = 2'h2} ees_dly_e;

  typedef struct packed {
    logic [1:0]  rsv;
    logic        seq_en;
    logic        trace;
    ees_act_e    action;
    logic [7:0]  probe;
    ees_area_e   area_sel;
    ees_bstate_e bus_sel;
    logic        area_any;
    logic        bus_any;
    ees_dir_e    dir;
    logic        size_word;
    logic        size_en;
    logic        use_mask;
    logic        dcmp;
    logic        outside;
    ees_amode_e  amode;
    logic        en;
  } ees_ctrl_s;
endpackage

// ===== pkg/ees_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface ees_link_if;
  import ees_pkg::*;
  logic [NCH-1:0][31:0]   ctrl;
  logic [NCH-1:0][31:0]   alo;
  logic [NCH-1:0][31:0]   ahi;
  logic [NCH-1:0][31:0]   dat;
  logic [NCH-1:0][31:0]   pass;
  logic [NCH-1:0][31:0]   seq;
  logic [31:0]            delay;
  logic [NTRIG-1:0][31:0] trig;
  logic [NCH-1:0]         sat;
  logic [31:0]            timer;
  logic                   timer_on;
  logic                   dly_busy;
  logic [AW-1:0]          addr;
  logic [DW-1:0]          data;
  logic                   write;
  logic                   word;
  ees_bstate_e            bstate;
  ees_area_e              area;
  logic [NPROBE-1:0]      probe;
  logic [NCH-1:0]         match;
  logic [NTRIG-1:0]       trig_hit;
  modport regs (output ctrl, alo, ahi, dat, pass, seq, delay, trig,
                input sat, timer, timer_on, dly_busy);
  modport cond (input ctrl, alo, ahi, dat, trig, addr, data, write, word,
                input bstate, area, probe, output match, trig_hit);
  modport core (input ctrl, pass, seq, delay, match, trig_hit,
                output sat, timer, timer_on, dly_busy, addr, data, write,
                output word, bstate, area, probe);
endinterface
`default_nettype wire

// ===== src/ees_cond.sv
`timescale 1ns/1ps
`default_nettype none
module ees_cond (
  ees_link_if.cond lk
);
  import ees_pkg::*;

  for (genvar c = 0; c < NCH; c++) begin : g_ch
    ees_ctrl_s         cf;
    logic [DW-1:0]     m;
    logic              in_rng;
    logic              a_ok;
    logic              d_ok;
    logic              dir_ok;
    logic              bs_ok;
    logic              ar_ok;
    logic [NPROBE-1:0] p_ok;
    assign cf = ees_ctrl_s'(lk.ctrl[c]);
    assign in_rng = (cf.amode == AM_SINGLE)
                  ? (lk.addr == lk.alo[c][AW-1:0])
                  : (lk.addr >= lk.alo[c][AW-1:0]
                     && lk.addr <= lk.ahi[c][AW-1:0]);
    // range channels cannot negate the range
    assign a_ok = (cf.amode == AM_ANY)
                || (in_rng ^ (cf.outside && (c < NEV)));
    assign m = cf.use_mask ? lk.dat[c][MASK_LSB +: DW] : '1;
    assign d_ok = !cf.dcmp
                || (((lk.data & m) == (lk.dat[c][DW-1:0] & m))
                    && (!cf.size_en || lk.word == cf.size_word));
    assign dir_ok = (cf.dir == DIR_ANY)
                  || (cf.dir == DIR_READ && !lk.write)
                  || (cf.dir == DIR_WRITE && lk.write);
    assign bs_ok = cf.bus_any || (lk.bstate == cf.bus_sel);
    assign ar_ok = cf.area_any || (lk.area == cf.area_sel);
    for (genvar p = 0; p < NPROBE; p++) begin : g_pr
      assign p_ok[p] = !((cf.probe[2*p +: 2] == PC_HIGH && !lk.probe[p])
                      || (cf.probe[2*p +: 2] == PC_LOW && lk.probe[p]));
    end
    assign lk.match[c] = cf.en && a_ok && d_ok && dir_ok && bs_ok
                       && ar_ok && (&p_ok);
  end

  for (genvar k = 0; k < NTRIG; k++) begin : g_trig
    assign lk.trig_hit[k] = lk.trig[k][TRIG_EN_BIT]
                          && lk.addr == lk.trig[k][AW-1:0];
  end
endmodule // ees_cond
`default_nettype wire

// ===== src/ees_regs.sv
`timescale 1ns/1ps
`default_nettype none
module ees_regs (
  input  wire logic                   clk_i,
  input  wire logic                   rstn_i,
  input  wire logic                   psel_i,
  input  wire logic                   penable_i,
  input  wire logic                   pwrite_i,
  input  wire logic [ees_pkg::PAW-1:0] paddr_i,
  input  wire logic [31:0]            pwdata_i,
  output logic      [31:0]            prdata_o,
  output logic                        pslverr_o,
  ees_link_if.regs                    lk
);
  import ees_pkg::*;

  typedef struct packed {
    logic [31:0]                      rdata;
    logic [NCH-1:0][NWORD-1:0][31:0]  ch;
    logic [31:0]                      delay;
    logic [NTRIG-1:0][31:0]           trig;
  } ees_regs_s;

  ees_regs_s      s;
  ees_regs_s      next_s;
  logic [PAW-1:0] off;
  logic [3:0]     ci;
  logic [2:0]     wi;
  logic           in_ch;
  logic           in_trig;
  logic           known;
  logic [31:0]    rd;

  always_comb begin
    next_s = s;
    off = paddr_i - A_CH;
    ci = off[CH_LSB +: 4];
    wi = off[4:2];
    in_ch = paddr_i >= A_CH && paddr_i < A_CH_END && wi < 3'(NWORD);
    in_trig = paddr_i[PAW-1:4] == A_TRIG[PAW-1:4];
    known = paddr_i[1:0] == 2'h0 && (in_ch || in_trig
            || paddr_i == A_DELAY || paddr_i == A_STATUS
            || paddr_i == A_TIMER);
    rd = '0;
    if (!known) begin
      rd = '0;
    end else if (in_ch) begin
      rd = s.ch[ci][wi];
    end else if (in_trig) begin
      rd = s.trig[paddr_i[3:2]];
    end else if (paddr_i == A_DELAY) begin
      rd = s.delay;
    end else if (paddr_i == A_STATUS) begin
      rd[NCH-1:0] = lk.sat;
      rd[ST_TIMER_BIT] = lk.timer_on;
      rd[ST_DLY_BIT] = lk.dly_busy;
    end else begin
      rd = lk.timer;
    end
    // read data is captured in the setup cycle, valid in the access cycle
    if (psel_i && !penable_i) begin
      next_s.rdata = rd;
    end
    if (psel_i && penable_i && pwrite_i && known) begin
      if (in_ch) begin
        next_s.ch[ci][wi] = pwdata_i;
      end else if (in_trig) begin
        next_s.trig[paddr_i[3:2]] = pwdata_i;
      end else if (paddr_i == A_DELAY) begin
        next_s.delay = pwdata_i & DLY_WMASK;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      s <= '0; // all configuration resets to CFG_RST, action break
    end else begin
      s <= next_s;
    end
  end

  assign prdata_o = s.rdata;
  assign pslverr_o = psel_i && penable_i && !known;
  assign lk.delay = s.delay;
  assign lk.trig = s.trig;
  for (genvar c = 0; c < NCH; c++) begin : g_out
    assign lk.ctrl[c] = s.ch[c][W_CTRL];
    assign lk.alo[c] = s.ch[c][W_ALO];
    assign lk.ahi[c] = s.ch[c][W_AHI];
    assign lk.dat[c] = s.ch[c][W_DATA];
    assign lk.pass[c] = s.ch[c][W_PASS];
    assign lk.seq[c] = s.ch[c][W_SEQ];
  end
endmodule // ees_regs
`default_nettype wire

// ===== src/ees_top.sv
// Operation
// - each channel matches bus cycle type, unless bus state is don't-care
// - each channel matches memory area, unless area is don't-care
// - four probe inputs each checked high, low or not at all
// - satisfied break event halts program; break is the reset default action
// - timer-start and timer-stop events control one readable run timer
// - break waits a programmed 16-bit number of bus cycles
// - single delay counter, so only one channel carries a delay
// - action fires only after the programmed number of occurrences
// - evaluation starts with run, all points not satisfied
// - satisfied state latches until program stops or point reset
// - latched point repeats no action until reset
// - program halt returns every point to not satisfied
// - armed points satisfy only while one arm source holds its state
// - one polarity per point: arm on satisfied or on not satisfied
// - reset event clears target points and their pass count
// - reset acts only on the source's transition to satisfied
// - any one of several reset sources resets the point
// - trace points take no action, only drive trace control and, on channel seven, the first probe connector pulse
// - four trigger channels compare address during program run
// - a disabled trigger channel never drives its output
// - matching trigger channel drives its pin high during access; registered, so high from the end of the access to the next bus cycle
// - channel seven pulses first probe connector low for a bus cycle
// - range channels lack negation, timer, pass count above one, sequencing
// - data compare masks both values, optional byte or word qualifier
`timescale 1ns/1ps
`default_nettype none
module ees_top (
  input  wire logic                        clk_i,
  input  wire logic                        rstn_i,
  input  wire logic                        psel_i,
  input  wire logic                        penable_i,
  input  wire logic                        pwrite_i,
  input  wire logic [ees_pkg::PAW-1:0]      paddr_i,
  input  wire logic [31:0]                 pwdata_i,
  output logic      [31:0]                 prdata_o,
  output logic                             pready_o,
  output logic                             pslverr_o,
  input  wire logic                        user_run_i,
  input  wire logic                        bus_valid_i,
  input  wire logic [ees_pkg::AW-1:0]       bus_addr_i,
  input  wire logic [ees_pkg::DW-1:0]       bus_data_i,
  input  wire logic                        bus_write_i,
  input  wire logic                        bus_word_i,
  input  wire ees_pkg::ees_bstate_e         bus_state_i,
  input  wire ees_pkg::ees_area_e           bus_area_i,
  input  wire logic [ees_pkg::NPROBE-1:0]   external_input_i,
  output logic                             break_req_o,
  output logic      [ees_pkg::NCH-1:0]      trace_hit_o,
  output logic                             first_probe_connector_n_o,
  output logic      [ees_pkg::NTRIG-1:0]    trigger_output_connector_o
);
  import ees_pkg::*;

  typedef struct packed {
    logic [NCH-1:0]         sat;
    logic [NCH-1:0][15:0]   cnt;
    logic                   run_q;
    logic                   timer_on;
    logic [31:0]            timer;
    ees_dly_e               dst;
    logic [15:0]            dcnt;
    logic                   brk;
    logic [NCH-1:0]         trace;
    logic                   ev_n;
    logic [NTRIG-1:0]       trig;
  } ees_core_s;

  ees_core_s      s;
  ees_core_s      next_s;
  ees_link_if     lk ();
  ees_ctrl_s      cf;
  logic [31:0]    sq;
  logic [15:0]    pc;
  logic [15:0]    dly;
  logic [3:0]     dch;
  logic [NCH-1:0] armsel;
  logic [NCH-1:0] newly;
  logic [NCH-1:0] rst;
  logic           seq_ok;
  logic           armed;
  logic           hit;

  ees_regs u_regs (
    .clk_i     (clk_i),
    .rstn_i    (rstn_i),
    .psel_i    (psel_i),
    .penable_i (penable_i),
    .pwrite_i  (pwrite_i),
    .paddr_i   (paddr_i),
    .pwdata_i  (pwdata_i),
    .prdata_o  (prdata_o),
    .pslverr_o (pslverr_o),
    .lk        (lk.regs)
  );

  ees_cond u_cond (
    .lk (lk.cond)
  );

  assign lk.addr = bus_addr_i;
  assign lk.data = bus_data_i;
  assign lk.write = bus_write_i;
  assign lk.word = bus_word_i;
  assign lk.bstate = bus_state_i;
  assign lk.area = bus_area_i;
  assign lk.probe = external_input_i;
  assign dly = lk.delay[15:0];
  assign dch = lk.delay[DLY_CH_LSB +: 4];

  always_comb begin
    next_s = s;
    cf = '0;
    sq = '0;
    pc = '0;
    armsel = '0;
    newly = '0;
    rst = '0;
    seq_ok = 1'b0;
    armed = 1'b0;
    hit = 1'b0;
    next_s.brk = 1'b0;
    next_s.trace = '0;
    next_s.run_q = user_run_i;
    if (s.timer_on && user_run_i) begin
      next_s.timer = s.timer + 32'h1;
    end
    if (user_run_i && !s.run_q) begin
      next_s.timer = '0;
    end
    if (!user_run_i) begin
      // halting the program drops every point and any pending delay
      next_s.sat = '0;
      next_s.cnt = '0;
      next_s.dst = DL_IDLE;
      next_s.dcnt = '0;
      next_s.ev_n = 1'b1;
      next_s.trig = '0;
    end else if (bus_valid_i) begin
      next_s.ev_n = 1'b1;
      next_s.trig = lk.trig_hit;
      if (s.dst == DL_WAIT) begin
        next_s.dcnt = s.dcnt - 16'h1;
        if (s.dcnt == 16'h1) begin
          next_s.brk = 1'b1;
          next_s.dst = DL_IDLE;
        end
      end
      for (int c = 0; c < NCH; c++) begin
        cf = ees_ctrl_s'(lk.ctrl[c]);
        sq = lk.seq[c];
        pc = lk.pass[c][15:0];
        seq_ok = cf.seq_en && (c < NEV);
        armsel = sq[NCH-1:0];
        // one polarity bit covers the whole arm set
        armed = !seq_ok || armsel == '0
              || |(armsel & (sq[ARM_INV_BIT] ? ~s.sat : s.sat));
        hit = lk.match[c] && armed && !s.sat[c];
        if (hit) begin
          if (c < NEV && pc > 16'h1 && (s.cnt[c] + 16'h1) < pc) begin
            next_s.cnt[c] = s.cnt[c] + 16'h1;
          end else begin
            newly[c] = 1'b1;
          end
        end
      end
      for (int c = 0; c < NCH; c++) begin
        cf = ees_ctrl_s'(lk.ctrl[c]);
        sq = lk.seq[c];
        // only a fresh transition resets, never a repeat match
        rst[c] = cf.seq_en && (c < NEV)
               && |(sq[RST_SEL_LSB +: NCH] & newly);
        next_s.sat[c] = (s.sat[c] || newly[c]) && !rst[c];
        if (rst[c]) begin
          next_s.cnt[c] = '0;
        end
        if (newly[c]) begin
          if (c == EV_OUT_CH) begin
            next_s.ev_n = 1'b0;
          end
          if (cf.trace) begin
            next_s.trace[c] = 1'b1;
          end else begin
            unique case (cf.action)
              ACT_BREAK: begin
                if (dch == 4'(c) && dly != 16'h0) begin
                  next_s.dst = DL_WAIT;
                  next_s.dcnt = dly;
                end else begin
                  next_s.brk = 1'b1;
                end
              end
              ACT_TSTART: begin
                if (c < NEV) begin
                  next_s.timer_on = 1'b1;
                end
              end
              ACT_TSTOP: begin
                if (c < NEV) begin
                  next_s.timer_on = 1'b0;
                end
              end
              default: begin
                next_s.brk = 1'b1;
              end
            endcase
          end
        end
      end
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      s <= '0;
      s.dst <= DL_IDLE;
      s.ev_n <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign lk.sat = s.sat;
  assign lk.timer = s.timer;
  assign lk.timer_on = s.timer_on;
  assign lk.dly_busy = s.dst == DL_WAIT;
  assign pready_o = 1'b1;
  assign break_req_o = s.brk;
  assign trace_hit_o = s.trace;
  assign first_probe_connector_n_o = s.ev_n;
  assign trigger_output_connector_o = s.trig;
endmodule // ees_top
`default_nettype wire

// ===== verification/ees_target_model.sv
`timescale 1ns/1ps
`default_nettype none
module ees_target_model (
  input  wire logic                      clk_i,
  output logic                           bus_valid_o,
  output logic [ees_pkg::AW-1:0]         bus_addr_o,
  output logic [ees_pkg::DW-1:0]         bus_data_o,
  output logic                           bus_write_o,
  output logic                           bus_word_o,
  output ees_pkg::ees_bstate_e           bus_state_o,
  output ees_pkg::ees_area_e             bus_area_o,
  output logic [ees_pkg::NPROBE-1:0]     probe_o
);
  import ees_pkg::*;
  initial begin
    bus_valid_o = 1'b0;
    bus_addr_o  = '0;
    bus_data_o  = '0;
    bus_write_o = 1'b0;
    bus_word_o  = 1'b0;
    bus_state_o = BS_OTHER;
    bus_area_o  = AR_XRAM;
    probe_o     = '0;
  end
  // one target bus cycle; lines scramble once the cycle is over
  task automatic cyc(input logic [AW-1:0] a, input ees_bstate_e s,
                     input ees_area_e r, input logic [NPROBE-1:0] p);
    @(posedge clk_i);
    bus_valid_o <= 1'b1;
    bus_addr_o  <= a;
    bus_data_o  <= 16'h5A5A;
    bus_write_o <= 1'b1;
    bus_word_o  <= 1'b1;
    bus_state_o <= s;
    bus_area_o  <= r;
    probe_o     <= p;
    @(posedge clk_i);
    bus_valid_o <= 1'b0;
    bus_addr_o  <= ~a;
    bus_data_o  <= 16'hA5A5;
    bus_state_o <= BS_OTHER;
    bus_area_o  <= AR_XRAM;
  endtask
endmodule // ees_target_model
`default_nettype wire

// ===== verification/ees_top_chk.sv
`timescale 1ns/1ps
`default_nettype none
module ees_top_chk (
  input wire logic                     clk_i,
  input wire logic                     rstn_i,
  input wire logic                     psel_i,
  input wire logic                     penable_i,
  input wire logic                     pslverr_o,
  input wire logic                     user_run_i,
  input wire logic                     bus_valid_i,
  input wire logic                     break_req_o,
  input wire logic [ees_pkg::NCH-1:0]   trace_hit_o,
  input wire logic                     first_probe_connector_n_o,
  input wire logic [ees_pkg::NTRIG-1:0] trigger_output_connector_o
);
  import ees_pkg::*;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  logic run_cyc;
  assign run_cyc = bus_valid_i && user_run_i;
  property p_brk_cause;
    break_req_o |-> $past(run_cyc);
  endproperty
  a_brk_cause: assert property (p_brk_cause)
    else $error("break without a monitored bus cycle");
  property p_halt;
    !user_run_i |=> !break_req_o && trace_hit_o == '0;
  endproperty
  a_halt: assert property (p_halt)
    else $error("action while halted");
  property p_trace_cause;
    |trace_hit_o |-> $past(run_cyc);
  endproperty
  a_trace_cause: assert property (p_trace_cause)
    else $error("trace hit without a monitored bus cycle");
  property p_trig_idle;
    !user_run_i |=> trigger_output_connector_o == '0;
  endproperty
  a_trig_idle: assert property (p_trig_idle)
    else $error("trigger pin driven while halted");
  property p_trig_hold;
    user_run_i && !bus_valid_i |=> $stable(trigger_output_connector_o);
  endproperty
  a_trig_hold: assert property (p_trig_hold)
    else $error("trigger pin changed between bus cycles");
  property p_ext_fall;
    $fell(first_probe_connector_n_o) |-> $past(run_cyc) || $past(run_cyc, 2);
  endproperty
  a_ext_fall: assert property (p_ext_fall)
    else $error("probe connector fell without a bus cycle");
  property p_ext_hold;
    !first_probe_connector_n_o && user_run_i && !bus_valid_i
      |=> !first_probe_connector_n_o;
  endproperty
  a_ext_hold: assert property (p_ext_hold)
    else $error("probe connector pulse shorter than a bus cycle");
  property p_ext_halt;
    !user_run_i |=> first_probe_connector_n_o;
  endproperty
  a_ext_halt: assert property (p_ext_halt)
    else $error("probe connector low while halted");
  property p_err_phase;
    pslverr_o |-> psel_i && penable_i;
  endproperty
  a_err_phase: assert property (p_err_phase)
    else $error("error response outside access phase");
endmodule // ees_top_chk
bind ees_top ees_top_chk u_chk (
  .clk_i(clk_i), .rstn_i(rstn_i), .psel_i(psel_i), .penable_i(penable_i),
  .pslverr_o(pslverr_o), .user_run_i(user_run_i),
  .bus_valid_i(bus_valid_i), .break_req_o(break_req_o),
  .trace_hit_o(trace_hit_o),
  .first_probe_connector_n_o(first_probe_connector_n_o),
  .trigger_output_connector_o(trigger_output_connector_o)
);
`default_nettype wire

// ===== verification/test_emulator_event_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
module test_emulator_event_sequencer;
  import ees_pkg::*;
  `define CHK(g, e) chk_val(32'(g), 32'(e))
  localparam logic [23:0] HA = 24'h001234;
  localparam logic [23:0] HB = 24'h005555;
  logic clk_i, rstn_i, psel_i, penable_i, pwrite_i, user_run_i, er;
  logic [PAW-1:0] paddr_i;
  logic [31:0] pwdata_i, prdata_o, rd;
  logic pready_o, pslverr_o, break_req_o, fpc_n, bv, bwr, bwd;
  logic [NCH-1:0] trace_hit_o;
  logic [NTRIG-1:0] trig;
  logic [AW-1:0] ba;
  logic [DW-1:0] bd;
  logic [NPROBE-1:0] ext;
  ees_bstate_e bs;
  ees_area_e br;
  int err_total, checks_done;
  ees_target_model mdl (.clk_i(clk_i), .bus_valid_o(bv), .bus_addr_o(ba),
    .bus_data_o(bd), .bus_write_o(bwr), .bus_word_o(bwd),
    .bus_state_o(bs), .bus_area_o(br), .probe_o(ext));
  ees_top dut (.clk_i(clk_i), .rstn_i(rstn_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
    .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
    .pslverr_o(pslverr_o), .user_run_i(user_run_i), .bus_valid_i(bv),
    .bus_addr_i(ba), .bus_data_i(bd), .bus_write_i(bwr), .bus_word_i(bwd),
    .bus_state_i(bs), .bus_area_i(br), .external_input_i(ext),
    .break_req_o(break_req_o), .trace_hit_o(trace_hit_o),
    .first_probe_connector_n_o(fpc_n),
    .trigger_output_connector_o(trig));
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  task automatic chk_val(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      err_total++;
      $display("[ERR] %0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic apb(input logic w, input logic [PAW-1:0] a,
                     input logic [31:0] d);
    @(posedge clk_i);
    psel_i    <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i  <= w;
    paddr_i   <= a;
    pwdata_i  <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    do @(posedge clk_i); while (pready_o !== 1'b1);
    rd = prdata_o;
    er = pslverr_o;
    psel_i    <= 1'b0;
    penable_i <= 1'b0;
  endtask
  task automatic rdchk(input logic [PAW-1:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    `CHK(rd, e);
  endtask
  task automatic wch(input int ch, input logic [2:0] w, input logic [31:0] d);
    apb(1'b1, A_CH + (PAW'(ch) << 5) + {7'h00, w, 2'h0}, d);
  endtask
  task automatic run(input logic v);
    @(posedge clk_i);
    user_run_i <= v;
  endtask
  task automatic ev(input logic [23:0] a, input ees_bstate_e s,
                    input ees_area_e r, input logic [3:0] p, input logic x);
    mdl.cyc(a, s, r, p);
    #1;
    `CHK(break_req_o, x);
  endtask
  initial begin
    #100us;
    err_total++;
    end_sim();
  end
  initial begin
    {rstn_i, psel_i, penable_i, pwrite_i, user_run_i} = '0;
    paddr_i = '0;
    pwdata_i = '0;
    repeat (16) @(posedge clk_i);
    rstn_i <= 1'b1;
    rdchk(A_CH, CFG_RST);
    rdchk(A_DELAY, 32'h0);
    rdchk(12'hFFC, 32'h0);
    `CHK(er, 1'b1);
    // channel 0: break on data cycle to HA in RAM with probe 1 high
    wch(0, W_CTRL, 32'h0004_9003);
    wch(0, W_ALO, {8'h00, HA});
    run(1'b1);
    ev(HA, BS_PREFETCH, AR_RAM, 4'h1, 1'b0);
    ev(HA, BS_DATA, AR_ROM, 4'h1, 1'b0);
    ev(HA, BS_DATA, AR_RAM, 4'h0, 1'b0);
    ev(HB, BS_DATA, AR_RAM, 4'h1, 1'b0);
    ev(HA, BS_DATA, AR_RAM, 4'h1, 1'b1);
    rdchk(A_STATUS, 32'h0000_0001);
    ev(HA, BS_DATA, AR_RAM, 4'h1, 1'b0);
    run(1'b0);
    rdchk(A_STATUS, 32'h0);
    ev(HA, BS_DATA, AR_RAM, 4'h1, 1'b0);
    wch(0, W_PASS, 32'h3);
    run(1'b1);
    ev(HA, BS_DATA, AR_RAM, 4'h1, 1'b0);
    ev(HA, BS_DATA, AR_RAM, 4'h1, 1'b0);
    ev(HA, BS_DATA, AR_RAM, 4'h1, 1'b1);
    run(1'b0);
    wch(0, W_PASS, 32'h0);
    apb(1'b1, A_DELAY, 32'h0000_0002);
    run(1'b1);
    ev(HA, BS_DATA, AR_RAM, 4'h1, 1'b0);
    ev(HB, BS_DATA, AR_RAM, 4'h1, 1'b0);
    ev(HB, BS_DATA, AR_RAM, 4'h1, 1'b1);
    run(1'b0);
    apb(1'b1, A_DELAY, 32'h0);
    // channel 0 starts the timer; channel 1 traces HB, armed by channel 0
    wch(0, W_CTRL, 32'h0404_9003);
    wch(1, W_CTRL, 32'h3000_0C03);
    wch(1, W_ALO, {8'h00, HB});
    wch(1, W_SEQ, 32'h0000_0001);
    apb(1'b1, A_TRIG, 32'h8000_ABCD);
    apb(1'b1, A_TRIG + 12'h004, 32'h0000_ABCD);
    run(1'b1);
    ev(HB, BS_DATA, AR_RAM, 4'h1, 1'b0);
    `CHK(trace_hit_o, 12'h000);
    ev(HA, BS_DATA, AR_RAM, 4'h1, 1'b0);
    rdchk(A_TIMER, 32'h1);
    rdchk(A_STATUS, 32'h0001_0001);
    ev(HB, BS_DATA, AR_RAM, 4'h1, 1'b0);
    `CHK(trace_hit_o, 12'h002);
    ev(24'h00ABCD, BS_DATA, AR_RAM, 4'h1, 1'b0);
    `CHK(trig, 4'h1);
    run(1'b0);
    // channel 1 now resets channel 0; range channel 8 ignores outside
    wch(0, W_CTRL, 32'h2004_9003);
    wch(0, W_SEQ, 32'h0002_0000);
    wch(8, W_ALO, 32'h0000_0300);
    wch(8, W_AHI, 32'h0000_03FF);
    wch(8, W_CTRL, 32'h0000_0C0D);
    run(1'b1);
    ev(HA, BS_DATA, AR_RAM, 4'h1, 1'b1);
    ev(HB, BS_DATA, AR_RAM, 4'h1, 1'b0);
    ev(HA, BS_DATA, AR_RAM, 4'h1, 1'b1);
    ev(HB, BS_DATA, AR_RAM, 4'h1, 1'b0);
    ev(HA, BS_DATA, AR_RAM, 4'h1, 1'b0);
    ev(24'h000380, BS_DATA, AR_RAM, 4'h1, 1'b1);
    run(1'b0);
    // channel 2: masked data compare, qualified by access size
    wch(2, W_DATA, 32'hFF00_5A00);
    wch(2, W_CTRL, 32'h0000_0C71);
    run(1'b1);
    ev(24'h000100, BS_DATA, AR_RAM, 4'h0, 1'b0);
    run(1'b0);
    wch(2, W_CTRL, 32'h0000_0CF1);
    run(1'b1);
    ev(24'h000100, BS_DATA, AR_RAM, 4'h0, 1'b1);
    run(1'b0);
    wch(7, W_CTRL, 32'h0000_0C01);
    run(1'b1);
    ev(24'h000000, BS_DMA, AR_IO8, 4'h0, 1'b1);
    @(posedge clk_i);
    #1;
    `CHK(fpc_n, 1'b0);
    run(1'b0);
    repeat (2) @(posedge clk_i);
    end_sim();
  end
endmodule // test_emulator_event_sequencer
`default_nettype wire
